// ---- logic/nest_irq_pkg.sv ----
// constants, types and behaviour list of the nested interrupt priority unit
// Behaviour
// - four software levels; a higher-level routine may preempt a lower-level one.
// - sixteen vectors, their assignment fixed in hardware.
// - vector addresses span FFE0h to FFFFh, ordered by fixed hardware priority.
// - reset and software trap are never masked.
// - one top-level event, maskable, ranked above all ordinary hardware requests.
// - current level held in condition code bits 5 (upper) and 3 (lower).
// - masking uses current level and per-vector programmed priority.
// - service starts only at the end of the current instruction.
// - program counter, index, accumulator and condition code pushed before service.
// - after the save, current level takes the serviced vector's programmed level; trap and top-level event load fixed level 3.
// - program counter then loads the serviced vector address; routine fetched there.
// - interrupt return pops all saved registers, restoring both level bits.
// - level codes: 0 is 10, 1 is 01, 2 is 00, 3 is 11 (disables).
// - enable instruction writes 10, disable instruction writes 11.
// - halt, pop condition code, enable, disable, wait change the current level.
package nest_irq_pkg;

    localparam int NUM_IRQ = 13;
    localparam int NUM_VEC = 16;
    localparam int NUM_PRIO_REGS = 4;

    localparam logic [3:0] VEC_RESET = 4'h0;
    localparam logic [3:0] VEC_TRAP = 4'h1;
    localparam logic [3:0] VEC_TOP_EVT = 4'h2;
    localparam logic [3:0] VEC_IRQ0 = 4'h3;
    localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;
    localparam logic [15:0] VEC_LOW_ADDR = 16'hffe0;

    localparam logic [1:0] LVL_MAIN = 2'b10;
    localparam logic [1:0] LVL_DISABLE = 2'b11;
    localparam logic [1:0] PRIO_RESET = 2'b11;
    localparam int FLAG_HI_BIT = 5;
    localparam int FLAG_LO_BIT = 3;

    localparam logic [7:0] OFS_PRIO0 = 8'h00;
    localparam logic [7:0] OFS_PRIO1 = 8'h04;
    localparam logic [7:0] OFS_PRIO2 = 8'h08;
    localparam logic [7:0] OFS_PRIO3 = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAVE = 2'b01,
        ST_VEC = 2'b10
    } state_e;

    typedef struct packed {
        state_e st;
        logic [1:0] lvl;
        logic [NUM_IRQ-1:0][1:0] prio;
        logic [3:0] vec;
        logic [1:0] vec_lvl;
        logic [15:0] vaddr;
        logic top_m;
        logic top_s;
        logic ack;
        logic [31:0] rdat;
    } state_s;

    localparam state_s STATE_RESET = '{
        st: ST_VEC,
        lvl: LVL_DISABLE,
        prio: {NUM_IRQ{PRIO_RESET}},
        vec: VEC_RESET,
        vec_lvl: LVL_DISABLE,
        vaddr: VEC_TOP_ADDR,
        top_m: 1'b0,
        top_s: 1'b0,
        ack: 1'b0,
        rdat: 32'h0000_0000
    };

    typedef struct packed {
        logic instr_end;
        logic trap;
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic halt;
        logic wait_irq_instr;
        logic popcc;
        logic interrupt_return_instr;
        logic [7:0] popped_flags;
    } core_evt_s;

endpackage : nest_irq_pkg

// ---- logic/nest_irq_unit.sv ----
// nested interrupt priority unit with wishbone priority registers
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module nest_irq_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // request sources
    input wire logic [nest_irq_pkg::NUM_IRQ-1:0] irq_i,
    input wire logic top_level_event_i,
    // core sequencer
    input wire nest_irq_pkg::core_evt_s evt_i,
    input wire logic save_done_i,
    output logic core_hold_o,
    output logic save_req_o,
    output logic pc_load_o,
    output logic [15:0] vector_addr_o,
    output logic level_bit_hi_o,
    output logic level_bit_lo_o
);

    nest_irq_pkg::state_s s_q;
    nest_irq_pkg::state_s s_d;
    logic [1:0] new_lvl;
    logic [1:0] cur_rank;
    logic [1:0] best_rank;
    logic [3:0] best_vec;
    logic take;
    logic lvl_evt;

    // level code to rank: 10->0, 01->1, 00->2, 11->3
    function automatic logic [1:0] lvl_rank(input logic [1:0] enc);
        lvl_rank = {~(enc[1] ^ enc[0]), enc[0]};
    endfunction : lvl_rank

    function automatic logic [15:0] vec_addr(input logic [3:0] v);
        vec_addr = nest_irq_pkg::VEC_TOP_ADDR - {11'h000, v, 1'b0};
    endfunction : vec_addr

    function automatic logic [7:0] prio_byte(input nest_irq_pkg::state_s s, input int k);
        logic [7:0] b;
        b = 8'h00;
        for (int j = 0; j < 4; j++) begin
            if (4 * k + j < nest_irq_pkg::NUM_IRQ) begin
                b[2*j +: 2] = s.prio[4*k+j];
            end
        end
        prio_byte = b;
    endfunction : prio_byte

    assign lvl_evt = evt_i.enable_irq_instr | evt_i.disable_irq_instr | evt_i.halt
        | evt_i.wait_irq_instr | evt_i.popcc | evt_i.interrupt_return_instr;

    always_comb begin
        s_d = s_q;
        new_lvl = s_q.lvl;
        cur_rank = 2'b00;
        best_rank = 2'b00;
        best_vec = nest_irq_pkg::VEC_RESET;
        take = 1'b0;
        // pin synchroniser, first stage read only by second
        s_d.top_m = top_level_event_i;
        s_d.top_s = s_q.top_m;
        // bus slave: one wait state, writes land with ack
        s_d.ack = cyc_i & stb_i & ~s_q.ack;
        s_d.rdat = 32'h0000_0000;
        if (s_d.ack) begin
            for (int k = 0; k < nest_irq_pkg::NUM_PRIO_REGS; k++) begin
                if (adr_i == 8'(4 * k)) begin
                    s_d.rdat = {24'h000000, prio_byte(s_q, k)};
                end
            end
            if (adr_i == nest_irq_pkg::OFS_STATUS) begin
                s_d.rdat = {23'h000000, s_q.top_s, s_q.vec, 1'b0,
                    (s_q.st != nest_irq_pkg::ST_IDLE), s_q.lvl};
            end
        end
        // write lands at the edge where the master samples ack high
        if (cyc_i && stb_i && s_q.ack && we_i && sel_i[0]) begin
            for (int k = 0; k < nest_irq_pkg::NUM_PRIO_REGS; k++) begin
                if (adr_i == 8'(4 * k)) begin
                    for (int j = 0; j < 4; j++) begin
                        if (4 * k + j < nest_irq_pkg::NUM_IRQ) begin
                            s_d.prio[4*k+j] = dat_i[2*j +: 2];
                        end
                    end
                end
            end
        end
        unique case (s_q.st)
            nest_irq_pkg::ST_IDLE: begin
                if (evt_i.instr_end) begin
                    // level-changing instructions act first
                    if (evt_i.enable_irq_instr || evt_i.halt || evt_i.wait_irq_instr) begin
                        new_lvl = nest_irq_pkg::LVL_MAIN;
                    end else if (evt_i.disable_irq_instr) begin
                        new_lvl = nest_irq_pkg::LVL_DISABLE;
                    end else if (evt_i.popcc || evt_i.interrupt_return_instr) begin
                        new_lvl = {evt_i.popped_flags[nest_irq_pkg::FLAG_HI_BIT],
                            evt_i.popped_flags[nest_irq_pkg::FLAG_LO_BIT]};
                    end
                    s_d.lvl = new_lvl;
                    cur_rank = lvl_rank(new_lvl);
                    // scan lowest hardware priority first so ties go upward
                    for (int i = nest_irq_pkg::NUM_IRQ - 1; i >= 0; i--) begin
                        if (irq_i[i] && lvl_rank(s_q.prio[i]) > cur_rank
                            && (!take || lvl_rank(s_q.prio[i]) >= best_rank)) begin
                            take = 1'b1;
                            best_rank = lvl_rank(s_q.prio[i]);
                            best_vec = 4'(i) + nest_irq_pkg::VEC_IRQ0;
                        end
                    end
                    // top-level event: fixed level 3, above every hardware line
                    if (s_q.top_s && cur_rank != 2'b11) begin
                        take = 1'b1;
                        best_rank = 2'b11;
                        best_vec = nest_irq_pkg::VEC_TOP_EVT;
                    end
                    if (evt_i.trap) begin
                        take = 1'b1;
                        best_rank = 2'b11;
                        best_vec = nest_irq_pkg::VEC_TRAP;
                    end
                    if (take) begin
                        s_d.st = nest_irq_pkg::ST_SAVE;
                        s_d.vec = best_vec;
                        s_d.vec_lvl = (best_vec == nest_irq_pkg::VEC_TRAP
                            || best_vec == nest_irq_pkg::VEC_TOP_EVT)
                            ? nest_irq_pkg::LVL_DISABLE
                            : s_q.prio[best_vec - nest_irq_pkg::VEC_IRQ0];
                    end
                end
            end
            nest_irq_pkg::ST_SAVE: begin
                // core pushes program counter, index, accumulator, flags
                if (save_done_i) begin
                    s_d.lvl = s_q.vec_lvl;
                    s_d.vaddr = vec_addr(s_q.vec);
                    s_d.st = nest_irq_pkg::ST_VEC;
                end
            end
            nest_irq_pkg::ST_VEC: begin
                s_d.st = nest_irq_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = nest_irq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= nest_irq_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign core_hold_o = (s_q.st != nest_irq_pkg::ST_IDLE);
    assign save_req_o = (s_q.st == nest_irq_pkg::ST_SAVE);
    assign pc_load_o = (s_q.st == nest_irq_pkg::ST_VEC);
    assign vector_addr_o = s_q.vaddr;
    assign level_bit_hi_o = s_q.lvl[1];
    assign level_bit_lo_o = s_q.lvl[0];

    default clocking dflt_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence boundary_idle_s;
        s_q.st == nest_irq_pkg::ST_IDLE && evt_i.instr_end;
    endsequence

    sequence save_finish_s;
        save_req_o && save_done_i;
    endsequence

    sequence vector_load_s;
        pc_load_o && vector_addr_o >= nest_irq_pkg::VEC_LOW_ADDR;
    endsequence

    entry_starts_save_a: assert property (boundary_idle_s ##0 take |=> save_req_o)
        else $error("accepted request did not start context save");

    save_then_level_a: assert property (save_finish_s |=> s_q.lvl == $past(s_q.vec_lvl))
        else $error("level not loaded from serviced vector after save");

    save_then_vector_a: assert property (save_finish_s |=> vector_load_s ##1 !pc_load_o)
        else $error("vector load did not follow the context save");

    vector_range_a: assert property (pc_load_o |-> vector_addr_o[0] == 1'b0
        && vector_addr_o >= nest_irq_pkg::VEC_LOW_ADDR)
        else $error("vector address outside the vector table");

    trap_taken_a: assert property (boundary_idle_s ##0 evt_i.trap
        |=> save_req_o && s_q.vec == nest_irq_pkg::VEC_TRAP)
        else $error("trap not serviced at once");

    enable_level_a: assert property (boundary_idle_s ##0 evt_i.enable_irq_instr
        |=> level_bit_hi_o && !level_bit_lo_o)
        else $error("enable instruction did not set level code 10");

    disable_level_a: assert property (boundary_idle_s ##0 evt_i.disable_irq_instr
        && !evt_i.enable_irq_instr && !evt_i.halt && !evt_i.wait_irq_instr
        |=> level_bit_hi_o && level_bit_lo_o)
        else $error("disable instruction did not set level code 11");

    return_level_a: assert property (boundary_idle_s ##0 evt_i.interrupt_return_instr
        && !evt_i.enable_irq_instr && !evt_i.disable_irq_instr && !evt_i.halt
        && !evt_i.wait_irq_instr
        |=> s_q.lvl == {$past(evt_i.popped_flags[5]), $past(evt_i.popped_flags[3])})
        else $error("interrupt return did not restore level bits");

    level3_masks_a: assert property (boundary_idle_s ##0 s_q.lvl == 2'b11
        && !lvl_evt && !evt_i.trap |=> !save_req_o)
        else $error("request accepted while level 3 disables");

    reset_vector_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
        |=> pc_load_o && vector_addr_o == nest_irq_pkg::VEC_TOP_ADDR)
        else $error("reset vector not loaded after reset");

    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single cycle after request");

    // entry sequence, level field and read-out checks
    sequence save_wait_s;
        save_req_o && !save_done_i;
    endsequence

    sequence idle_quiet_s;
        s_q.st == nest_irq_pkg::ST_IDLE && !evt_i.instr_end;
    endsequence

    save_holds_a: assert property (save_wait_s |=> save_req_o)
        else $error("context save request dropped before the core finished");

    save_no_vector_a: assert property (save_req_o |-> !pc_load_o)
        else $error("vector load while context save still runs");

    pc_load_single_a: assert property (pc_load_o |=> !pc_load_o)
        else $error("vector load longer than one cycle");

    pc_after_save_a: assert property (pc_load_o && !$past(rst_i)
        |-> $past(save_req_o && save_done_i))
        else $error("vector load without a finished context save");

    save_level_stable_a: assert property (save_wait_s |=> $stable(s_q.lvl))
        else $error("level changed before the context save finished");

    busy_ignores_end_a: assert property (core_hold_o && !save_done_i
        |=> $stable(s_q.lvl))
        else $error("level changed while the entry sequence runs");

    vec_stable_busy_a: assert property (core_hold_o |=> $stable(s_q.vec))
        else $error("serviced vector changed during entry");

    vaddr_stable_a: assert property (!(save_req_o && save_done_i)
        |=> $stable(vector_addr_o))
        else $error("vector address changed outside the save end");

    no_reset_vector_a: assert property (pc_load_o && !$past(rst_i)
        |-> vector_addr_o != nest_irq_pkg::VEC_TOP_ADDR)
        else $error("reset vector loaded without reset");

    low_vector_a: assert property (pc_load_o
        && s_q.vec == 4'(nest_irq_pkg::NUM_VEC - 1)
        |-> vector_addr_o == nest_irq_pkg::VEC_LOW_ADDR)
        else $error("last vector not at the bottom of the table");

    trap_level_a: assert property (save_finish_s
        ##0 s_q.vec == nest_irq_pkg::VEC_TRAP |=> s_q.lvl == nest_irq_pkg::LVL_DISABLE)
        else $error("trap service did not load level 3");

    top_event_a: assert property (boundary_idle_s ##0 s_q.top_s
        && !evt_i.trap && !lvl_evt && s_q.lvl != nest_irq_pkg::LVL_DISABLE
        |=> save_req_o && s_q.vec == nest_irq_pkg::VEC_TOP_EVT)
        else $error("top-level event not taken above ordinary requests");

    top_event_level_a: assert property (save_finish_s
        ##0 s_q.vec == nest_irq_pkg::VEC_TOP_EVT |=> s_q.lvl == nest_irq_pkg::LVL_DISABLE)
        else $error("top-level event service did not load level 3");

    quiet_no_entry_a: assert property (boundary_idle_s ##0 !evt_i.trap
        && !s_q.top_s && irq_i == '0 |=> !save_req_o)
        else $error("entry started with no request pending");

    halt_level_a: assert property (boundary_idle_s ##0 evt_i.halt
        |=> level_bit_hi_o && !level_bit_lo_o)
        else $error("halt did not drop to main level");

    wait_level_a: assert property (boundary_idle_s ##0 evt_i.wait_irq_instr
        |=> level_bit_hi_o && !level_bit_lo_o)
        else $error("wait instruction did not drop to main level");

    pop_level_a: assert property (boundary_idle_s ##0 evt_i.popcc
        && !evt_i.enable_irq_instr && !evt_i.disable_irq_instr && !evt_i.halt
        && !evt_i.wait_irq_instr
        |=> s_q.lvl == {$past(evt_i.popped_flags[5]), $past(evt_i.popped_flags[3])})
        else $error("flag pop did not load the level bits");

    idle_level_stable_a: assert property (idle_quiet_s |=> $stable(s_q.lvl))
        else $error("level changed with no instruction end");

    preempt_rank_a: assert property (boundary_idle_s ##0 take && !evt_i.trap
        && best_vec != nest_irq_pkg::VEC_TOP_EVT
        |=> lvl_rank(s_q.vec_lvl) > lvl_rank(s_q.lvl))
        else $error("request accepted at or below the current level");

    idle_data_zero_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside the ack cycle");

    upper_zero_a: assert property (ack_o |-> dat_o[31:9] == 23'h000000)
        else $error("unused read data bits not zero");

    ack_needs_request_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("bus ack without a request");

    write_lands_a: assert property (cyc_i && stb_i && ack_o && we_i && sel_i[0]
        && adr_i == nest_irq_pkg::OFS_PRIO0 |=> s_q.prio[0] == $past(dat_i[1:0]))
        else $error("priority write did not land at the ack edge");

    sync_delay_a: assert property ($rose(s_q.top_s) |-> $past(top_level_event_i, 2))
        else $error("top-level event not passed through two stages");

    entry_at_end_a: assert property ($rose(save_req_o)
        |-> $past(s_q.st == nest_irq_pkg::ST_IDLE && evt_i.instr_end))
        else $error("entry began away from an instruction end");

endmodule : nest_irq_unit

// ---- tb/core_seq_model.sv ----
// core sequencer model: condition code stack and instruction ends
`timescale 1ns/1ns
module core_seq_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic save_req_i,
    input wire logic level_bit_hi_i,
    input wire logic level_bit_lo_i,
    output nest_irq_pkg::core_evt_s evt_o,
    output logic save_done_o
);
    int save_delay = 0;
    int wait_cnt = 0;
    logic [7:0] stack_q[$];
    initial evt_o = '0;
    initial save_done_o = 1'b0;
    always @(posedge clk_i) begin
        save_done_o <= 1'b0;
        wait_cnt <= save_req_i ? wait_cnt + 1 : 0;
        if (rst_i) stack_q.delete();
        else if (save_req_i && !save_done_o && wait_cnt >= save_delay) begin
            stack_q.push_back({2'b00, level_bit_hi_i, 1'b0, level_bit_lo_i, 3'b000});
            save_done_o <= 1'b1;
        end
    end
    // a return fetches its condition code from the stack
    task automatic exec(input nest_irq_pkg::core_evt_s e);
        if (e.interrupt_return_instr) e.popped_flags = stack_q.pop_back();
        evt_o <= e;
        @(posedge clk_i);
        evt_o <= '0;
    endtask : exec
endmodule : core_seq_model

// ---- tb/nest_irq_unit_tb.sv ----
// self-checking bench of the nested interrupt priority unit
`timescale 1ns/1ns
module nest_irq_unit_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [12:0] irq_i = 13'h0;
    logic top_level_event_i = 1'b0;
    nest_irq_pkg::core_evt_s evt_i;
    logic [15:0] vector_addr_o;
    logic ack_o, save_done_i, core_hold_o, save_req_o, pc_load_o;
    logic level_bit_hi_o, level_bit_lo_o;
    int num_errors = 0;
    int checked = 0;
    // level instruction, expected level code on top
    logic [17:0] ops[7] = '{18'h2a000, 18'h39000, 18'h28800, 18'h39000, 18'h28400,
        18'h18208, 18'h39000};
    always #5 clk_i = ~clk_i;
    nest_irq_unit dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .irq_i, .top_level_event_i, .evt_i, .save_done_i, .core_hold_o, .save_req_o,
        .pc_load_o, .vector_addr_o, .level_bit_hi_o, .level_bit_lo_o);
    core_seq_model cpu_u (.clk_i, .rst_i, .save_req_i(save_req_o), .evt_o(evt_i),
        .level_bit_hi_i(level_bit_hi_o), .level_bit_lo_i(level_bit_lo_o),
        .save_done_o(save_done_i));
    task automatic check_bus(input logic [31:0] act, input logic [31:0] exp);
        checked++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, act, exp);
        end
    endtask : check_bus
    task automatic check_core(input logic [15:0] act, input logic [15:0] exp);
        check_bus({16'h0, act}, {16'h0, exp});
    endtask : check_core
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        if (ack_o !== 1'b1) num_errors++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic step(input logic [15:0] e, input logic [1:0] lv);
        cpu_u.exec(e);
        @(negedge clk_i);
        check_core({13'h0, save_req_o, level_bit_hi_o, level_bit_lo_o}, {14'h0, lv});
        @(posedge clk_i);
    endtask : step
    task automatic enter(input logic [15:0] e, input logic [15:0] va, input logic [1:0] lv);
        int n = 0;
        cpu_u.exec(e);
        while (pc_load_o !== 1'b1 && n++ < 20) @(negedge clk_i);
        check_core(vector_addr_o, va);
        check_core({14'h0, level_bit_hi_o, level_bit_lo_o}, {14'h0, lv});
        @(posedge clk_i);
    endtask : enter
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check_core(vector_addr_o, 16'hfffe);
        check_core({14'h0, level_bit_hi_o, level_bit_lo_o}, 16'h0003);
        $display("test reset done");
        wb(1'b0, 8'h00, 32'h0);
        check_bus(rd, 32'hff);
        wb(1'b1, 8'h00, 32'hc1);
        wb(1'b1, 8'h0c, 32'h01);
        wb(1'b1, 8'h20, 32'hff);
        wb(1'b0, 8'h00, 32'h0);
        check_bus(rd, 32'hc1);
        wb(1'b0, 8'h20, 32'h0);
        check_bus(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        check_bus(rd, 32'h3);
        $display("test registers done");
        foreach (ops[i]) step(ops[i][15:0], ops[i][17:16]);
        $display("test levels done");
        irq_i <= 13'h0001;
        step(16'h8000, 2'b11);
        enter(16'ha000, 16'hfff8, 2'b01);
        irq_i <= 13'h0007;
        repeat (3) @(posedge clk_i);
        check_core({15'h0, core_hold_o}, 16'h0);
        enter(16'h8000, 16'hfff6, 2'b00);
        irq_i <= 13'h0000;
        step(16'h8100, 2'b01);
        step(16'h8100, 2'b10);
        $display("test nesting done");
        cpu_u.save_delay = 3;
        enter(16'hc000, 16'hfffc, 2'b11);
        wb(1'b0, 8'h10, 32'h0);
        check_bus(rd, 32'h13);
        step(16'h8100, 2'b10);
        $display("test trap done");
        irq_i <= 13'h1000;
        top_level_event_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        enter(16'h8000, 16'hfffa, 2'b11);
        top_level_event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        enter(16'h8100, 16'hffe0, 2'b01);
        $display("test top level done");
        stop_test();
    end
endmodule : nest_irq_unit_tb
